// >>> core/crbs_sequencer.sv
// Behaviour
// - after acceptance three vector bytes from ffff00..ffff02 fill the counter low to high.
// - acceptance clears the system stack pointer to zero.
// - acceptance sets the interrupt mask level field to seven.
// - acceptance clears the register bank pointer field to bank zero.
// - when the pin returns high the core starts at the loaded program counter.
// - all other core registers keep their contents across reset.
// - acceptance returns the peripheral control register to its reset value.
// - acceptance turns every port pin into an input.
// - internal reset ends in the cycle the pin is seen high once the vector fetch is done, with no delay counter.
// - strap pattern 10 starts an 8-bit bus and 01 a 16-bit bus, both with dynamic sizing.
// - the program counter and address path are 24 bits wide.
// - the straps are held at one of the two legal patterns only; any other pattern sets o_strap_error and selects the 8-bit bus.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`include "crbs_regs.svh"

module crbs_sequencer #(
    parameter int ADDR_W      = 24,
    parameter int PORT_W      = 32,
    parameter int GPR_DEPTH   = 16,
    parameter int HOLD_CYCLES = `CRBS_MIN_HOLD_CYCLES
)(
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    input  wire logic              i_reset_pin_n,
    input  wire logic              i_bus_width_strap_msb,
    input  wire logic              i_bus_width_strap_lsb,
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [31:0]       i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic      [31:0]       o_reg_rdata,
    output logic                   o_fetch_req,
    output logic      [ADDR_W-1:0] o_fetch_addr,
    input  wire logic [7:0]        i_fetch_data,
    input  wire logic              i_fetch_valid,
    output logic      [ADDR_W-1:0] o_program_counter,
    output logic      [31:0]       o_system_stack_pointer,
    output logic      [2:0]        o_interrupt_mask_level,
    output logic      [1:0]        o_register_bank_pointer,
    output logic                   o_cpu_run,
    output logic                   o_exec_start,
    output logic                   o_periph_rst,
    output logic      [31:0]       o_periph_ctrl,
    output logic      [PORT_W-1:0] o_port_oe,
    output logic                   o_bus_16bit,
    output logic                   o_strap_error
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam int GPR_AW = $clog2(GPR_DEPTH);

    if (ADDR_W != 24) begin : g_bad_addr
        $error("crbs_sequencer: ADDR_W must be 24 to reach the vector");
    end
    if (GPR_DEPTH < 2 || GPR_DEPTH > 16 || (1 << GPR_AW) != GPR_DEPTH) begin : g_bad_gpr
        $error("crbs_sequencer: GPR_DEPTH must be a power of two, 2 to 16");
    end
    if (PORT_W < 1 || PORT_W > 32) begin : g_bad_port
        $error("crbs_sequencer: PORT_W must be 1 to 32");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    crbs_pkg::crbs_state_t    state;
    crbs_pkg::crbs_state_t    next_state;
    crbs_pkg::crbs_byte_idx_t byte_idx;
    logic                     was_running;
    logic [1:0]               strap_q;
    logic                     in_reset;
    logic                     accept;
    logic                     last_byte;
    logic [31:0]              sw_word;
    logic [31:0]              stat_word;
    logic [31:0]              next_rdata;
    logic [31:0]              rdata_q;
    logic                     rd_gpr_q;
    logic [31:0]              gpr_rdata;
    logic                     gpr_hit;
    logic                     sw_wr_ok;

    // ------------------------------------------------------------
    // reset qualifier
    // ------------------------------------------------------------
    crbs_rst_if u_rst_if ();

    assign u_rst_if.pin_low = !i_reset_pin_n;

    crbs_rst_qual #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_rst_qual (
        .i_mclk      (i_mclk),
        .i_rst_n     (i_rst_n),
        .rst         (u_rst_if)
    );

    // acceptance only counts while waiting in the hold state
    assign accept    = (state == crbs_pkg::CRBS_HOLD) && u_rst_if.accepted;
    assign last_byte = (byte_idx == 2'h2) && i_fetch_valid;

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            crbs_pkg::CRBS_IDLE:
            begin
                if (u_rst_if.pin_low)
                    next_state = crbs_pkg::CRBS_HOLD;
            end
            crbs_pkg::CRBS_RUN:
            begin
                if (u_rst_if.pin_low)
                    next_state = crbs_pkg::CRBS_HOLD;
            end
            crbs_pkg::CRBS_HOLD:
            begin
                // a short low pulse is ignored and the core resumes
                if (accept)
                    next_state = crbs_pkg::CRBS_FETCH;
                else if (u_rst_if.released)
                    next_state = was_running ? crbs_pkg::CRBS_RUN : crbs_pkg::CRBS_IDLE;
            end
            crbs_pkg::CRBS_FETCH:
            begin
                // start straight away if the pin is already high
                if (last_byte)
                    next_state = u_rst_if.released ? crbs_pkg::CRBS_RUN
                                                   : crbs_pkg::CRBS_WAIT;
            end
            crbs_pkg::CRBS_WAIT:
            begin
                if (u_rst_if.released)
                    next_state = crbs_pkg::CRBS_RUN;
            end
            default:
            begin
                next_state = crbs_pkg::CRBS_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state <= crbs_pkg::CRBS_IDLE;
        else
            state <= next_state;
    end

    // remembers whether a short pulse should resume the core
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            was_running <= 1'b0;
        else if (accept)
            was_running <= 1'b0;
        else if (state == crbs_pkg::CRBS_RUN)
            was_running <= 1'b1;
    end

    // internal reset spans acceptance through the vector fetch and up to the pin release
    assign in_reset = accept
                   || (state == crbs_pkg::CRBS_FETCH)
                   || (state == crbs_pkg::CRBS_WAIT);

    // ------------------------------------------------------------
    // vector fetch
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            byte_idx <= 2'h0;
        else if (accept)
            byte_idx <= 2'h0;
        else if ((state == crbs_pkg::CRBS_FETCH) && i_fetch_valid && (byte_idx != 2'h2))
            byte_idx <= byte_idx + 2'h1;
    end

    // fetch request and vector address, byte by byte
    always_comb
    begin
        o_fetch_req = (state == crbs_pkg::CRBS_FETCH);
        case (byte_idx)
            2'h0:    o_fetch_addr = `CRBS_VEC_BYTE0;
            2'h1:    o_fetch_addr = `CRBS_VEC_BYTE1;
            default: o_fetch_addr = `CRBS_VEC_BYTE2;
        endcase
    end

    // program counter loads one vector byte per answer, low byte first
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_program_counter <= '0;
        else if ((state == crbs_pkg::CRBS_FETCH) && i_fetch_valid)
        begin
            case (byte_idx)
                2'h0:    o_program_counter[7:0]   <= i_fetch_data;
                2'h1:    o_program_counter[15:8]  <= i_fetch_data;
                default: o_program_counter[23:16] <= i_fetch_data;
            endcase
        end
    end

    // ------------------------------------------------------------
    // core start
    // ------------------------------------------------------------
    // one pulse as the core leaves reset with the vector in place
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_exec_start <= 1'b0;
        else
            o_exec_start <= (state != crbs_pkg::CRBS_RUN)
                         && (state != crbs_pkg::CRBS_HOLD)
                         && (next_state == crbs_pkg::CRBS_RUN);
    end

    // core keeps running through an unaccepted low pulse
    assign o_cpu_run    = (state == crbs_pkg::CRBS_RUN)
                       || ((state == crbs_pkg::CRBS_HOLD) && was_running);
    assign o_periph_rst = in_reset;

    // ------------------------------------------------------------
    // bus width straps
    // ------------------------------------------------------------
    // sampled every cycle in the hold state, before acceptance
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            strap_q <= `CRBS_STRAP_8BIT;
        else if (state == crbs_pkg::CRBS_HOLD)
            strap_q <= {i_bus_width_strap_msb, i_bus_width_strap_lsb};
    end

    // width latched at acceptance, ahead of the first fetch
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_bus_16bit   <= 1'b0;
            o_strap_error <= 1'b0;
        end
        else if (accept)
        begin
            case (strap_q)
                `CRBS_STRAP_16BIT:
                begin
                    o_bus_16bit   <= 1'b1;
                    o_strap_error <= 1'b0;
                end
                `CRBS_STRAP_8BIT:
                begin
                    o_bus_16bit   <= 1'b0;
                    o_strap_error <= 1'b0;
                end
                default:
                begin
                    o_bus_16bit   <= 1'b0;
                    o_strap_error <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // forced core registers
    // ------------------------------------------------------------
    // software writes, except to the general registers, are held off while internal reset is active
    assign sw_wr_ok = i_reg_wr && !in_reset;

    // system stack pointer
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_system_stack_pointer <= `CRBS_RST_SP;
        else if (accept)
            o_system_stack_pointer <= `CRBS_RST_SP;
        else if (sw_wr_ok && (i_reg_addr == `CRBS_OFS_SP))
            o_system_stack_pointer <= i_reg_wdata;
    end

    // status word: mask level and bank pointer
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_interrupt_mask_level  <= `CRBS_RST_IML;
            o_register_bank_pointer <= `CRBS_RST_RBP;
        end
        else if (accept)
        begin
            o_interrupt_mask_level  <= `CRBS_RST_IML;
            o_register_bank_pointer <= `CRBS_RST_RBP;
        end
        else if (sw_wr_ok && (i_reg_addr == `CRBS_OFS_SW))
        begin
            o_interrupt_mask_level  <= i_reg_wdata[`CRBS_SW_IML_LSB +: 3];
            o_register_bank_pointer <= i_reg_wdata[`CRBS_SW_RBP_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // peripheral control and port direction
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_periph_ctrl <= `CRBS_RST_PERIPH;
        else if (accept)
            o_periph_ctrl <= `CRBS_RST_PERIPH;
        else if (sw_wr_ok && (i_reg_addr == `CRBS_OFS_PERIPH))
            o_periph_ctrl <= i_reg_wdata;
    end

    // one enable per port pin, high drives the pin
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_port_oe <= PORT_W'(`CRBS_RST_PORTDIR);
        else if (accept)
            o_port_oe <= PORT_W'(`CRBS_RST_PORTDIR);
        else if (sw_wr_ok && (i_reg_addr == `CRBS_OFS_PORTDIR))
            o_port_oe <= i_reg_wdata[PORT_W-1:0];
    end

    // ------------------------------------------------------------
    // general registers, untouched by reset
    // ------------------------------------------------------------
    assign gpr_hit = ((i_reg_addr & `CRBS_GPR_MASK) == `CRBS_OFS_GPR)
                  && ({1'b0, i_reg_addr[3:0]} < 5'(GPR_DEPTH));

    crbs_gpr_mem #(
        .WIDTH     (32),
        .DEPTH     (GPR_DEPTH)
    ) u_gpr_mem (
        .i_mclk    (i_mclk),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (i_reg_wr && gpr_hit),
        .i_wr_addr (i_reg_addr[GPR_AW-1:0]),
        .i_wr_data (i_reg_wdata),
        .i_rd_en   (i_reg_rd && gpr_hit),
        .i_rd_addr (i_reg_addr[GPR_AW-1:0]),
        .o_rd_data (gpr_rdata)
    );

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // read words assembled from live state
    always_comb
    begin
        sw_word                                  = 32'h00000000;
        sw_word[`CRBS_SW_IML_LSB +: 3]           = o_interrupt_mask_level;
        sw_word[`CRBS_SW_RBP_LSB +: 2]           = o_register_bank_pointer;
        stat_word                                = 32'h00000000;
        stat_word[`CRBS_STAT_BUS16]              = o_bus_16bit;
        stat_word[`CRBS_STAT_SERR]               = o_strap_error;
        stat_word[`CRBS_STAT_RUN]                = o_cpu_run;
        stat_word[`CRBS_STAT_INRST]              = in_reset;
    end

    // address decode, unmapped reads give zero
    always_comb
    begin
        case (i_reg_addr)
            `CRBS_OFS_PC:      next_rdata = {8'h00, o_program_counter};
            `CRBS_OFS_SP:      next_rdata = o_system_stack_pointer;
            `CRBS_OFS_SW:      next_rdata = sw_word;
            `CRBS_OFS_PORTDIR: next_rdata = 32'(o_port_oe);
            `CRBS_OFS_PERIPH:  next_rdata = o_periph_ctrl;
            `CRBS_OFS_STAT:    next_rdata = stat_word;
            default:           next_rdata = 32'h00000000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rdata_q  <= 32'h00000000;
            rd_gpr_q <= 1'b0;
        end
        else
        begin
            rdata_q  <= (i_reg_rd && !gpr_hit) ? next_rdata : 32'h00000000;
            rd_gpr_q <= i_reg_rd && gpr_hit;
        end
    end

    assign o_reg_rdata = rd_gpr_q ? gpr_rdata : rdata_q;

endmodule : crbs_sequencer

// >>> core/crbs_regs.svh
`ifndef CRBS_REGS_SVH
`define CRBS_REGS_SVH

// reset acceptance
`define CRBS_MIN_HOLD_CYCLES 20

// reset vector bytes and reserved top of space
`define CRBS_VEC_BYTE0   24'hffff00
`define CRBS_VEC_BYTE1   24'hffff01
`define CRBS_VEC_BYTE2   24'hffff02
`define CRBS_RSV_BASE    24'hfffff0

// register port offsets
`define CRBS_OFS_PC      8'h00
`define CRBS_OFS_SP      8'h01
`define CRBS_OFS_SW      8'h02
`define CRBS_OFS_PORTDIR 8'h03
`define CRBS_OFS_PERIPH  8'h04
`define CRBS_OFS_STAT    8'h05
`define CRBS_OFS_GPR     8'h10
`define CRBS_GPR_MASK    8'hf0

// status word field positions
`define CRBS_SW_IML_LSB  0
`define CRBS_SW_RBP_LSB  4

// status register bit positions
`define CRBS_STAT_BUS16  0
`define CRBS_STAT_SERR   1
`define CRBS_STAT_RUN    2
`define CRBS_STAT_INRST  3

// values forced when reset is accepted
`define CRBS_RST_SP      32'h00000000
`define CRBS_RST_IML     3'h7
`define CRBS_RST_RBP     2'h0
`define CRBS_RST_PORTDIR 32'h00000000
`define CRBS_RST_PERIPH  32'h00000000

// strap patterns {msb, lsb}
`define CRBS_STRAP_8BIT  2'h2
`define CRBS_STRAP_16BIT 2'h1

`endif

// >>> core/crbs_pkg.sv
package crbs_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        CRBS_IDLE,
        CRBS_HOLD,
        CRBS_FETCH,
        CRBS_WAIT,
        CRBS_RUN
    } crbs_state_t;

    // vector byte index
    typedef logic [1:0] crbs_byte_idx_t;

endpackage : crbs_pkg

// >>> core/crbs_rst_if.sv
interface crbs_rst_if;
    logic pin_low;
    logic accepted;
    logic released;

    // qualifier drives the verdict
    modport qual (
        input  pin_low,
        output accepted,
        output released
    );

    // sequencer feeds the pin level
    modport seq (
        output pin_low,
        input  accepted,
        input  released
    );
endinterface : crbs_rst_if

// >>> core/crbs_rst_qual.sv
`include "crbs_regs.svh"

module crbs_rst_qual #(
    parameter int HOLD_CYCLES = `CRBS_MIN_HOLD_CYCLES
)(
    input  wire logic   i_mclk,
    input  wire logic   i_rst_n,
    crbs_rst_if.qual    rst
);
    localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

    if (HOLD_CYCLES < 1) begin : g_bad_hold
        $error("crbs_rst_qual: HOLD_CYCLES must be at least 1");
    end

    logic [CNT_W-1:0] low_cnt;

    // ------------------------------------------------------------
    // consecutive low cycle counter, saturating
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            low_cnt <= '0;
        else if (!rst.pin_low)
            low_cnt <= '0;
        else if (low_cnt != CNT_W'(HOLD_CYCLES))
            low_cnt <= low_cnt + 1'b1;
    end

    // accept on the last required low sample, release at once
    assign rst.accepted = rst.pin_low && (low_cnt == CNT_W'(HOLD_CYCLES - 1));
    assign rst.released = !rst.pin_low;

endmodule : crbs_rst_qual

// >>> core/crbs_gpr_mem.sv
module crbs_gpr_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
)(
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
    input  wire logic [WIDTH-1:0]         i_wr_data,
    input  wire logic                     i_rd_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
    output logic      [WIDTH-1:0]         o_rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ------------------------------------------------------------
    // storage: no reset branch, reset never touches contents
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_wr_en)
            mem[i_wr_addr] <= i_wr_data;
    end

    // registered read data
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rd_data <= '0;
        else if (i_rd_en)
            o_rd_data <= mem[i_rd_addr];
    end

endmodule : crbs_gpr_mem

// >>> bench/crbs_props.sv
`include "crbs_regs.svh"
module crbs_props #(
    parameter int ADDR_W      = 24,
    parameter int PORT_W      = 32,
    parameter int HOLD_CYCLES = `CRBS_MIN_HOLD_CYCLES
)(
    input wire logic              i_mclk,
    input wire logic              i_rst_n,
    input wire logic              i_reset_pin_n,
    input wire logic              o_fetch_req,
    input wire logic [ADDR_W-1:0] o_fetch_addr,
    input wire logic [31:0]       o_system_stack_pointer,
    input wire logic [2:0]        o_interrupt_mask_level,
    input wire logic [1:0]        o_register_bank_pointer,
    input wire logic              o_exec_start,
    input wire logic              o_periph_rst,
    input wire logic [31:0]       o_periph_ctrl,
    input wire logic [PORT_W-1:0] o_port_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------
    // hold counter
    // --------------
    logic [7:0] low_cnt;

    // consecutive cycles the pin was seen low
    always_ff @(posedge i_mclk or negedge i_rst_n)
        if (!i_rst_n)
            low_cnt <= 8'h00;
        else if (i_reset_pin_n)
            low_cnt <= 8'h00;
        else if (low_cnt != 8'hff)
            low_cnt <= low_cnt + 8'h01;

    // --------------
    // properties
    // --------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    hold_count_a: assert property ($rose(o_periph_rst) |-> low_cnt == HOLD_CYCLES - 1)
        else $error("reset accepted after wrong hold");
    sp_clear_a: assert property ($rose(o_periph_rst) |=> o_system_stack_pointer == 32'h0)
        else $error("stack pointer not cleared");
    mask_seven_a: assert property ($rose(o_periph_rst) |=> o_interrupt_mask_level == 3'h7)
        else $error("mask level not seven");
    bank_zero_a: assert property ($rose(o_periph_rst) |=> o_register_bank_pointer == 2'h0)
        else $error("bank not zero");
    port_input_a: assert property ($rose(o_periph_rst) |=> o_port_oe == '0)
        else $error("port still driving");
    periph_init_a: assert property ($rose(o_periph_rst) |=> o_periph_ctrl == 32'h0)
        else $error("peripheral control not reset");
    vec_first_a: assert property ($rose(o_fetch_req) |-> o_fetch_addr == `CRBS_VEC_BYTE0)
        else $error("first fetch address wrong");
    release_run_a: assert property (o_periph_rst && i_reset_pin_n && !o_fetch_req |=> o_exec_start)
        else $error("start late after release");
endmodule : crbs_props

bind crbs_sequencer crbs_props #(
    .ADDR_W(ADDR_W), .PORT_W(PORT_W), .HOLD_CYCLES(HOLD_CYCLES)
) props_u (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reset_pin_n(i_reset_pin_n),
    .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
    .o_system_stack_pointer(o_system_stack_pointer),
    .o_interrupt_mask_level(o_interrupt_mask_level),
    .o_register_bank_pointer(o_register_bank_pointer),
    .o_exec_start(o_exec_start), .o_periph_rst(o_periph_rst),
    .o_periph_ctrl(o_periph_ctrl), .o_port_oe(o_port_oe)
);

// >>> bench/crbs_vec_model.sv
module crbs_vec_model (
    input  wire logic        i_mclk,
    input  wire logic        i_fetch_req,
    input  wire logic [23:0] i_fetch_addr,
    input  wire logic [23:0] i_vector,
    input  wire logic [1:0]  i_stall,
    output logic      [7:0]  o_fetch_data,
    output logic             o_fetch_valid,
    output logic             o_reset_pin_n,
    output logic      [1:0]  o_strap
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt = 2'h0;

    // idle levels at time zero
    initial
    begin
        o_fetch_data  = 8'h00;
        o_fetch_valid = 1'b0;
        o_reset_pin_n = 1'b1;
        o_strap       = 2'h1;
    end

    // vector bytes after a stall, data toggles while idle
    always @(posedge i_mclk)
    begin
        o_fetch_valid <= 1'b0;
        o_fetch_data  <= ~o_fetch_data;
        if (i_fetch_req && !o_fetch_valid)
            wait_cnt <= wait_cnt + 2'h1;
        if (i_fetch_req && !o_fetch_valid && wait_cnt >= i_stall)
        begin
            o_fetch_valid <= 1'b1;
            o_fetch_data  <= i_vector[8 * i_fetch_addr[1:0] +: 8];
            wait_cnt      <= 2'h0;
        end
    end

    // pin held low for a cycle count with a strap pattern
    task automatic hold_low(input int cycles, input logic [1:0] strap);
        @(posedge i_mclk);
        o_reset_pin_n <= 1'b0;
        o_strap       <= strap;
        repeat (cycles) @(posedge i_mclk);
        o_reset_pin_n <= 1'b1;
    endtask : hold_low
endmodule : crbs_vec_model

// >>> bench/test_cpu_reset_boot_sequencer.sv
`include "crbs_regs.svh"
module test_cpu_reset_boot_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------
    // signals
    // --------------
    logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
    logic        fvalid, freq, pin_n, start, b16, serr;
    logic [1:0]  stall = 2'h0, strap;
    logic [7:0]  addr = 8'h00, fdata;
    logic [23:0] vec = 24'h0, faddr, pcnt;
    logic [31:0] wdata = 32'h0, rdata, sp, pctl;
    int          num_errors = 0, compares = 0;

    always #2.5 clk = ~clk;

    crbs_sequencer dut_u (
        .i_mclk(clk), .i_rst_n(rst_n), .i_reset_pin_n(pin_n),
        .i_bus_width_strap_msb(strap[1]), .i_bus_width_strap_lsb(strap[0]),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_fetch_req(freq), .o_fetch_addr(faddr),
        .i_fetch_data(fdata), .i_fetch_valid(fvalid), .o_program_counter(pcnt),
        .o_system_stack_pointer(sp), .o_interrupt_mask_level(), .o_register_bank_pointer(),
        .o_cpu_run(), .o_exec_start(start), .o_periph_rst(), .o_periph_ctrl(pctl),
        .o_port_oe(), .o_bus_16bit(b16), .o_strap_error(serr)
    );

    crbs_vec_model partner_u (
        .i_mclk(clk), .i_fetch_req(freq), .i_fetch_addr(faddr), .i_vector(vec),
        .i_stall(stall), .o_fetch_data(fdata), .o_fetch_valid(fvalid),
        .o_reset_pin_n(pin_n), .o_strap(strap)
    );

    // --------------
    // tasks
    // --------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    task automatic t_accept();
        logic [31:0] d;
        int          n;
        vec = 24'h3c5a96;
        n   = 0;
        reg_wr(`CRBS_OFS_SP, 32'h12345678);
        reg_wr(`CRBS_OFS_SW, 32'h00000023);
        reg_wr(`CRBS_OFS_PERIPH, 32'hdeadbeef);
        reg_wr(`CRBS_OFS_PORTDIR, 32'hffffffff);
        reg_wr(`CRBS_OFS_GPR, 32'h5a5aa5a5);
        partner_u.hold_low(19, 2'h2);
        repeat (3) @(posedge clk);
        check("short pulse sp", 32'h12345678, sp);
        partner_u.hold_low(20, 2'h2);
        while (start !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1 n++;
        end
        check("exec start", 32'h1, {31'h0, start});
        check("program counter", {8'h0, vec}, {8'h0, pcnt});
        check("stack pointer", 32'h0, sp);
        check("periph ctrl", 32'h0, pctl);
        check("bus width", 32'h0, {30'h0, serr, b16});
        reg_rd(`CRBS_OFS_SW, d);
        check("status word", 32'h7, d);
        reg_rd(`CRBS_OFS_PORTDIR, d);
        check("port dir", 32'h0, d);
        reg_rd(`CRBS_OFS_GPR, d);
        check("gpr kept", 32'h5a5aa5a5, d);
        reg_rd(8'h08, d);
        check("unmapped read", 32'h0, d);
        reg_rd(`CRBS_OFS_STAT, d);
        check("status run", 32'h4, d);
    endtask : t_accept

    task automatic t_modes();
        logic [1:0] pats [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
        for (int i = 0; i < 4; i++)
        begin
            vec   = 24'h0f1e2d + 24'(i * 24'h010101);
            stall = 2'(i);
            partner_u.hold_low(40, pats[i]);
            @(posedge clk);
            #1;
            check("release timing", 32'h1, {31'h0, start});
            check("program counter", {8'h0, vec}, {8'h0, pcnt});
            check("bus 16", {31'h0, pats[i] == 2'h1}, {31'h0, b16});
            check("strap error", {31'h0, pats[i][1] == pats[i][0]}, {31'h0, serr});
        end
    endtask : t_modes

    task automatic close_out();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // --------------
    // run
    // --------------
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_accept();
        t_modes();
        close_out();
    end

    // watchdog well beyond the expected run
    initial
    begin
        #20us;
        num_errors++;
        close_out();
    end
endmodule : test_cpu_reset_boot_sequencer
